// File: core/cps_regs.sv
// Register bank for channel function, I/O pin control and scan sequencing.
// Assumes a simple synchronous register port driven by the serial interface
// logic, and a conversion engine that pulses conv_done per conversion.
// Pin levels on pad_in are taken as already synchronous to sys_clk.
//
// Summary of operation
// RULE_01: A one in the channel function register makes that pin an I/O, a zero an analog input.
// RULE_02: A one in the direction register makes that I/O an output, a zero an input.
// RULE_03: A one in the drive register makes that output push-pull, a zero open-drain.
// RULE_04: Each I/O output drives the level held in its output level bit.
// RULE_05: The input level register is read-only and reports the level seen on each I/O pin.
// RULE_06: Writing go as one starts an ascending scan of enabled channels, writing zero stops it.
// RULE_07: The go control acts only while the scan mode field holds auto.
// RULE_08: Scan mode zero is manual, one is auto, two and three are reserved.
// RULE_09: In manual mode the channel id field picks channels zero to seven, higher codes reserved.
// RULE_10: The host must not pick in manual mode a channel that is set as an I/O.
// RULE_11: Reserved bits of the scan control and channel select registers read zero.
// RULE_12: Every configuration register resets to zero.
// RULE_13: An eight-bit mask picks which channels the auto scan visits.
// RULE_14: Direction, drive and level reach a pin only while it is an I/O.
`timescale 1ns/1ns
`default_nettype none
`include "cps_params.svh"

module cps_regs #(
   parameter int NUM_CH = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic conv_done,
   output logic [3:0] conv_channel,
   output logic conv_channel_valid,
   output logic seq_running,
   input wire logic [NUM_CH-1:0] pad_in,
   output logic [NUM_CH-1:0] pad_out,
   output logic [NUM_CH-1:0] pad_oe
);

   // ==========================================================
   // Stored configuration
   logic [NUM_CH-1:0] channel_function_select;
   logic [NUM_CH-1:0] io_direction_select;
   logic [NUM_CH-1:0] output_drive_type;
   logic [NUM_CH-1:0] output_level_set;
   logic [NUM_CH-1:0] input_level_readback;
   logic [NUM_CH-1:0] scan_enable_mask;
   logic sequence_go;
   cps_pkg::cps_mode_t scan_mode;
   logic [3:0] manual_channel_id;
   // Sequencer state and channel pointers
   cps_pkg::cps_seq_state_t seq_state;
   logic [3:0] seq_channel;
   logic [3:0] next_seq_channel;
   logic [3:0] first_channel;
   logic auto_armed;
   logic go_write;
   logic [7:0] next_rdata;

   // Decoded write strobes
   // Called only from clocked processes, which re-read the bus at every edge
   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = reg_wr && (reg_addr == ofs);
   endfunction

   // ==========================================================
   // Pin configuration registers
   // One process per register keeps each write decode on its own
   // Channel function: a set bit hands the pin to the I/O logic
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         channel_function_select <= NUM_CH'(`CPS_RST_BYTE); // see RULE_12
      end else if (wr_hit(`CPS_OFS_FUNCTION)) begin
         channel_function_select <= reg_wdata[NUM_CH-1:0]; // see RULE_01
      end
   end

   // Direction: a set bit turns the I/O into an output
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         io_direction_select <= NUM_CH'(`CPS_RST_BYTE); // see RULE_12
      end else if (wr_hit(`CPS_OFS_DIRECTION)) begin
         io_direction_select <= reg_wdata[NUM_CH-1:0]; // see RULE_02
      end
   end

   // Drive type: a set bit picks push-pull over open-drain
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         output_drive_type <= NUM_CH'(`CPS_RST_BYTE); // see RULE_12
      end else if (wr_hit(`CPS_OFS_DRIVE)) begin
         output_drive_type <= reg_wdata[NUM_CH-1:0]; // see RULE_03
      end
   end

   // Output level: only reaches the pad on an output I/O
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         output_level_set <= NUM_CH'(`CPS_RST_BYTE); // see RULE_12
      end else if (wr_hit(`CPS_OFS_OUT_LEVEL)) begin
         output_level_set <= reg_wdata[NUM_CH-1:0]; // see RULE_04
      end
   end

   // Scan mask: a set bit puts the channel into the auto scan
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         scan_enable_mask <= NUM_CH'(`CPS_RST_BYTE); // see RULE_12
      end else if (wr_hit(`CPS_OFS_SCAN_MASK)) begin
         scan_enable_mask <= reg_wdata[NUM_CH-1:0]; // see RULE_13
      end
   end

   // ==========================================================
   // Scan control and manual channel select
   // Only the defined fields are stored, so reserved bits cannot hold data
   // Scan control: go and mode always arrive together in one byte
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sequence_go <= 1'b0; // see RULE_12
         scan_mode <= cps_pkg::cps_mode_t'(`CPS_RST_MODE);
      end else if (wr_hit(`CPS_OFS_SCAN_CTRL)) begin
         sequence_go <= reg_wdata[`CPS_GO_BIT]; // see RULE_06
         scan_mode <= cps_pkg::cps_mode_t'(reg_wdata[`CPS_MODE_MSB:`CPS_MODE_LSB]); // see RULE_08
      end
   end

   // Manual channel id: reserved codes are kept and marked invalid later
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         manual_channel_id <= `CPS_RST_CHID; // see RULE_12
      end else if (wr_hit(`CPS_OFS_MANUAL_SEL)) begin
         manual_channel_id <= reg_wdata[`CPS_CHID_MSB:`CPS_CHID_LSB]; // see RULE_09
      end
   end

   // ==========================================================
   // Channel search helpers
   // Lowest enabled channel strictly above cur, else wrap to lowest enabled
   // Plain priority search over a few bits, small enough to stay combinational
   function automatic logic [3:0] next_enabled(input logic [NUM_CH-1:0] mask,
                                               input logic [3:0] cur);
      logic [3:0] low;
      logic [3:0] above;
      logic found_low;
      logic found_above;
      low = 4'h0;
      above = 4'h0;
      found_low = 1'b0;
      found_above = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (mask[i] && !found_low) begin
            low = 4'(i);
            found_low = 1'b1;
         end
         if (mask[i] && !found_above && (4'(i) > cur)) begin
            above = 4'(i);
            found_above = 1'b1;
         end
      end
      next_enabled = found_above ? above : low;
   endfunction

   assign first_channel = next_enabled(scan_enable_mask, 4'hf);
   assign next_seq_channel = next_enabled(scan_enable_mask, seq_channel);
   // Go only counts in auto mode and with at least one channel enabled
   assign auto_armed = sequence_go && (scan_mode == cps_pkg::CPS_MODE_AUTO)
                       && (scan_enable_mask != '0); // see RULE_07
   // Decoded in the open: a function call in a continuous assignment
   // would not wake up when reg_wr or reg_addr change
   assign go_write = reg_wr && (reg_addr == `CPS_OFS_SCAN_CTRL) && reg_wdata[`CPS_GO_BIT];

   // ==========================================================
   // Auto sequencer
   // A fresh go write restarts from the lowest channel, even mid-scan
   // Limitation: a new mask only shows at the next conv_done, but a
   // cleared mask stops the scan at once
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seq_state <= cps_pkg::CPS_SEQ_IDLE;
         seq_channel <= 4'h0;
      end else begin
         unique case (seq_state)
            cps_pkg::CPS_SEQ_IDLE: begin
               if (auto_armed) begin
                  seq_state <= cps_pkg::CPS_SEQ_RUN; // see RULE_06
                  seq_channel <= first_channel;
               end
            end
            cps_pkg::CPS_SEQ_RUN: begin
               if (!auto_armed) begin
                  seq_state <= cps_pkg::CPS_SEQ_IDLE; // see RULE_06
               end else if (go_write) begin
                  seq_channel <= first_channel;
               end else if (conv_done) begin
                  seq_channel <= next_seq_channel; // see RULE_13
               end
            end
            default: begin
               seq_state <= cps_pkg::CPS_SEQ_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Channel handed to the converter
   // Reserved modes and reserved channel codes give no valid channel;
   // an I/O channel picked in manual mode is the host's problem
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         conv_channel <= 4'h0;
         conv_channel_valid <= 1'b0;
      end else begin
         if (scan_mode == cps_pkg::CPS_MODE_MANUAL) begin
            conv_channel <= manual_channel_id; // see RULE_09
            conv_channel_valid <= (manual_channel_id < 4'(NUM_CH)); // see RULE_09
         end else if (scan_mode == cps_pkg::CPS_MODE_AUTO) begin
            conv_channel <= seq_channel; // see RULE_08
            conv_channel_valid <= (seq_state == cps_pkg::CPS_SEQ_RUN);
         end else begin
            conv_channel <= 4'h0;
            conv_channel_valid <= 1'b0;
         end
      end
   end

   // Running flag follows the state but drops with the mode at once, so it
   // never stands while the channel output is already marked invalid
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seq_running <= 1'b0;
      end else begin
         seq_running <= (seq_state == cps_pkg::CPS_SEQ_RUN)
                        && (scan_mode == cps_pkg::CPS_MODE_AUTO); // see RULE_07
      end
   end

   // ==========================================================
   // Pin cells
   // Each cell registers its own pad outputs so they leave from flops
   for (genvar g = 0; g < NUM_CH; g++) begin : g_pin
      cps_pin_cell u_cell (
         .sys_clk(sys_clk),
         .resetn(resetn),
         .is_io(channel_function_select[g]),
         .is_output(io_direction_select[g]),
         .push_pull(output_drive_type[g]),
         .level(output_level_set[g]),
         .pad_in(pad_in[g]),
         .pad_out(pad_out[g]),
         .pad_oe(pad_oe[g]),
         .sensed(input_level_readback[g])
      );
   end

   // ==========================================================
   // Read mux
   // Unmapped offsets and reserved bits read as zero
   // A read in the same cycle as a write returns the old value
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         `CPS_OFS_FUNCTION: next_rdata[NUM_CH-1:0] = channel_function_select;
         `CPS_OFS_DIRECTION: next_rdata[NUM_CH-1:0] = io_direction_select;
         `CPS_OFS_DRIVE: next_rdata[NUM_CH-1:0] = output_drive_type;
         `CPS_OFS_OUT_LEVEL: next_rdata[NUM_CH-1:0] = output_level_set;
         `CPS_OFS_IN_LEVEL: next_rdata[NUM_CH-1:0] = input_level_readback; // see RULE_05
         `CPS_OFS_SCAN_CTRL: begin
            next_rdata[`CPS_GO_BIT] = sequence_go; // see RULE_11
            next_rdata[`CPS_MODE_MSB:`CPS_MODE_LSB] = scan_mode;
         end
         `CPS_OFS_MANUAL_SEL: next_rdata[`CPS_CHID_MSB:`CPS_CHID_LSB] = manual_channel_id; // see RULE_11
         `CPS_OFS_SCAN_MASK: next_rdata[NUM_CH-1:0] = scan_enable_mask;
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data is registered so the serial side sees a stable byte;
   // it holds the last answer until the next read
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata; // see RULE_05
      end
   end

   // Answer strobe: exactly one cycle after each read strobe
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

endmodule // cps_regs

`default_nettype wire

// File: core/cps_params.svh
// Constants for the channel pin, I/O and scan configuration register bank.
// Assumes an 8-bit register port with an 8-bit address.
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH

// ==========================================================
// Register offsets
`define CPS_OFS_FUNCTION 8'h05
`define CPS_OFS_DIRECTION 8'h07
`define CPS_OFS_DRIVE 8'h09
`define CPS_OFS_OUT_LEVEL 8'h0b
`define CPS_OFS_IN_LEVEL 8'h0d
`define CPS_OFS_SCAN_CTRL 8'h10
`define CPS_OFS_MANUAL_SEL 8'h11
`define CPS_OFS_SCAN_MASK 8'h12

// ==========================================================
// Field positions and widths
`define CPS_GO_BIT 4
`define CPS_MODE_MSB 1
`define CPS_MODE_LSB 0
`define CPS_CHID_MSB 3
`define CPS_CHID_LSB 0

// ==========================================================
// Reset values
`define CPS_RST_BYTE 8'h00
`define CPS_RST_MODE 2'h0
`define CPS_RST_CHID 4'h0

`endif

// File: core/cps_pkg.sv
// Types for the channel pin, I/O and scan configuration register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package cps_pkg;

   // Scan mode field encodings; codes 2 and 3 are reserved
   typedef enum logic [1:0] {
      CPS_MODE_MANUAL = 2'h0,
      CPS_MODE_AUTO = 2'h1,
      CPS_MODE_RSVD2 = 2'h2,
      CPS_MODE_RSVD3 = 2'h3
   } cps_mode_t;

   // Sequencer states
   typedef enum logic [1:0] {
      CPS_SEQ_IDLE = 2'h0,
      CPS_SEQ_RUN = 2'h1
   } cps_seq_state_t;

endpackage

// File: core/cps_pin_cell.sv
// One channel pin: turns the function, direction, drive and level bits
// into registered pad output and output enable, and samples the pad input.
// Assumes the pad input is synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none

module cps_pin_cell (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic is_io,
   input wire logic is_output,
   input wire logic push_pull,
   input wire logic level,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic sensed
);

   logic drive_on;

   // ==========================================================
   // Output stage
   // Settings only reach the pin while the channel is an I/O
   assign drive_on = is_io & is_output; // see RULE_14

   // Open-drain only pulls low; push-pull drives both levels;
   // an undriven pin never shows a high level on pad_out
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
      end else begin
         pad_out <= drive_on & push_pull & level; // see RULE_03
         pad_oe <= drive_on & (push_pull | ~level); // see RULE_04
      end
   end

   // ==========================================================
   // Input readback
   // Analog channels read zero so stray analog levels are not reported
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sensed <= 1'b0;
      end else begin
         sensed <= is_io & pad_in; // see RULE_05
      end
   end

endmodule // cps_pin_cell

`default_nettype wire

// File: verif/cps_regs_chk.sv
// Checker for the channel pin, I/O and scan register bank.
// Assumes it is bound onto cps_regs, one sys_clk domain.
`timescale 1ns/1ns
`default_nettype none
`include "cps_params.svh"

module cps_regs_chk #(
   parameter int NUM_CH = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic conv_done,
   input wire logic [3:0] conv_channel,
   input wire logic conv_channel_valid,
   input wire logic seq_running,
   input wire logic [NUM_CH-1:0] pad_out,
   input wire logic [NUM_CH-1:0] pad_oe
);
   // ==========================================================
   // Helper: last scan mode written, so go can be judged
   logic [1:0] mode_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Shadow of the mode field, kept apart from the design's copy
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= 2'h0;
      end else if (reg_wr && reg_addr == `CPS_OFS_SCAN_CTRL) begin
         mode_q <= reg_wdata[1:0];
      end
   end

   // Two quiet run cycles: no advance and no new setting
   sequence quiet_run;
      (seq_running && !conv_done && !reg_wr) [*2];
   endsequence

   // ==========================================================
   // Properties
   rvalid_follow_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read gave no answer");
   rvalid_cause_a: assert property (!reg_rd |=> !reg_rvalid)
      else $error("answer without a read");
   scan_rsvd_a: assert property (reg_rd && reg_addr == `CPS_OFS_SCAN_CTRL |=>
      reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0) else $error("scan spare bits set");
   sel_rsvd_a: assert property (reg_rd && reg_addr == `CPS_OFS_MANUAL_SEL |=>
      reg_rdata[7:4] == 4'h0) else $error("select spare bits set");
   chan_range_a: assert property (conv_channel_valid |-> conv_channel < 4'h8)
      else $error("valid channel above seven");
   run_valid_a: assert property (seq_running |-> conv_channel_valid)
      else $error("running with no channel");
   chan_hold_a: assert property (quiet_run ##1 seq_running |-> $stable(conv_channel))
      else $error("channel moved without done");
   drive_out_a: assert property ((pad_out & ~pad_oe) == '0)
      else $error("high level without drive");
   go_manual_a: assert property (mode_q != 2'h1 |-> ##2 !seq_running)
      else $error("scan ran outside auto");
endmodule // cps_regs_chk

bind cps_regs cps_regs_chk #(.NUM_CH(NUM_CH)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_done(conv_done),
   .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid),
   .seq_running(seq_running), .pad_out(pad_out), .pad_oe(pad_oe));
`default_nettype wire

// File: verif/cps_pin_world.sv
// Board side of the eight channel pins: pull-ups and outside drivers.
// Assumes outside drivers only act on pins the block leaves undriven.
`timescale 1ns/1ns
`default_nettype none

module cps_pin_world (
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] level
);
   // A released pin floats up on its pull-up, never keeps its old value
   assign level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en);
endmodule // cps_pin_world
`default_nettype wire

// File: verif/channel_pin_gpio_sequence_cfg_bench.sv
// Bench for the channel pin, I/O and scan register bank.
// Assumes cps_regs, the pin model and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`include "cps_params.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module channel_pin_gpio_sequence_cfg_bench;
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} cps_row_t;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic conv_done = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] reg_rdata, pad_in, pad_out, pad_oe;
   logic reg_rvalid, conv_channel_valid, seq_running;
   logic [3:0] conv_channel;
   int miscompares = 0;
   int comparisons = 0;
   // Reset reads first, then write and read back each place
   cps_row_t rows [17] = '{'{1'b0, 8'h05, 8'h00, 8'h00}, '{1'b0, 8'h07, 8'h00, 8'h00},
      '{1'b0, 8'h09, 8'h00, 8'h00}, '{1'b0, 8'h0b, 8'h00, 8'h00},
      '{1'b0, 8'h0d, 8'h00, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'h00},
      '{1'b0, 8'h11, 8'h00, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'h00},
      '{1'b1, 8'h07, 8'ha5, 8'ha5}, '{1'b1, 8'h09, 8'h3c, 8'h3c},
      '{1'b1, 8'h0b, 8'h5a, 8'h5a}, '{1'b1, 8'h0d, 8'hff, 8'h00},
      '{1'b1, 8'h10, 8'hff, 8'h13}, '{1'b1, 8'h11, 8'hff, 8'h0f},
      '{1'b1, 8'h12, 8'h81, 8'h81}, '{1'b1, 8'h05, 8'hf0, 8'hf0},
      '{1'b1, 8'h05, 8'h00, 8'h00}};

   cps_regs #(.NUM_CH(8)) dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .conv_done(conv_done), .conv_channel(conv_channel),
      .conv_channel_valid(conv_channel_valid), .seq_running(seq_running),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
   cps_pin_world u_pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
      .ext_val(ext_val), .level(pad_in));

   // ==========================================================
   // Clock, bus tasks and closing
   always #20 sys_clk = ~sys_clk;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Answer stands one cycle only, so it is looked at right after the edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, e)
   endtask

   // Outputs follow a setting two edges later
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic step;
      @(posedge sys_clk);
      conv_done <= 1'b1;
      @(posedge sys_clk);
      conv_done <= 1'b0;
      settle();
   endtask

   task automatic finish_test;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      finish_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      $display("test register table done");
      wr(8'h05, 8'hff);
      wr(8'h07, 8'h0f);
      wr(8'h09, 8'h03);
      wr(8'h0b, 8'h05);
      @(posedge sys_clk);
      ext_en <= 8'hf0;
      ext_val <= 8'h50;
      settle();
      `CHK({pad_oe, pad_out}, 16'h0b01)
      rd(8'h0d, 8'h55);
      wr(8'h05, 8'h0f);
      rd(8'h0d, 8'h05);
      wr(8'h05, 8'h00);
      settle();
      `CHK({pad_oe, pad_out}, 16'h0000)
      $display("test pins done");
      wr(8'h12, 8'h05);
      wr(8'h10, 8'h11);
      settle();
      `CHK({seq_running, conv_channel_valid, conv_channel}, 6'h30)
      step();
      `CHK(conv_channel, 4'h2)
      step();
      `CHK(conv_channel, 4'h0)
      wr(8'h10, 8'h01);
      settle();
      `CHK(seq_running, 1'b0)
      wr(8'h11, 8'h07); // channel 7 is analog here
      wr(8'h10, 8'h10);
      settle();
      `CHK({seq_running, conv_channel_valid, conv_channel}, 6'h17)
      wr(8'h11, 8'h08);
      settle();
      `CHK(conv_channel_valid, 1'b0)
      wr(8'h10, 8'h12);
      settle();
      `CHK({seq_running, conv_channel_valid}, 2'h0)
      wr(8'h12, 8'h00);
      wr(8'h10, 8'h11);
      settle();
      `CHK(seq_running, 1'b0)
      $display("test sequencer done");
      wr(8'h12, 8'h05);
      settle();
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      #1;
      `CHK(seq_running, 1'b0)
      rd(8'h12, 8'h00);
      rd(8'h10, 8'h00);
      $display("test second reset done");
      finish_test();
   end
endmodule // channel_pin_gpio_sequence_cfg_bench
`default_nettype wire
